// file: core/pmta_core.sv
// table read and table write execution with pointer update
// Notes on behaviour
// - keep a 21-bit byte pointer into program memory, 2-Mbyte range
// - pointer bit 0 picks low (0) or high (1) byte of a word
// - table accesses always use the pointer, not an operand
// - table read modes: unchanged, post-inc, post-dec, pre-inc
// - pre-increment read bumps pointer first, then reads new address
// - post-decrement read reads current address, then decrements
// - table write supports the same four pointer modes
// - table write stores latch in holding register set by low 3 bits
// - table write only loads holding registers for later programming
// - each table instruction takes two cycles, transfer in the second
// - no arithmetic status flag is changed by either instruction
`timescale 1ns/1ps
`default_nettype none
`include "pmta_defs.svh"
module pmta_core #(
  parameter int PTR_W  = `PMTA_PTR_W,
  parameter int DATA_W = `PMTA_DATA_W,
  parameter int HOLD_N = `PMTA_HOLD_N,
  parameter int SEL_W  = `PMTA_HOLD_SEL_W
) (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic [1:0]               q_phase,
  input  wire logic                     instr_valid,
  input  wire logic [7:0]               instr_low,
  input  wire logic                     ptr_load,
  input  wire logic [PTR_W-1:0]         ptr_load_value,
  input  wire logic                     latch_load,
  input  wire logic [DATA_W-1:0]        latch_load_value,
  input  wire logic [DATA_W-1:0]        mem_rdata,
  output logic      [PTR_W-1:0]         mem_addr,
  output logic                          mem_rd,
  output logic                          byte_high,
  output logic      [PTR_W-1:0]         table_pointer,
  output logic      [DATA_W-1:0]        table_latch,
  output logic                          busy,
  output logic                          done,
  output logic                          status_we,
  output logic      [HOLD_N*DATA_W-1:0] hold_data
);
  logic                     rst_meta;
  logic                     rst_n;
  pmta_pkg::pmta_state_t    state;
  pmta_pkg::pmta_mode_t     mode;
  logic [DATA_W-1:0]        wr_byte;
  logic                     hold_load;
  logic [SEL_W-1:0]         hold_sel;
  logic [PTR_W-1:0]         hold_data_sel;
  logic                     take_read;
  logic                     take_write;

  // reset release through two flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p,
                                            input logic dn);
    // modulo width, no carry out
    step = dn ? PTR_W'(p - 1'b1) : PTR_W'(p + 1'b1);
  endfunction

  function automatic logic is_op(input logic [7:0] w, input logic [5:0] op);
    is_op = (w[`PMTA_OPC_MSB+2:`PMTA_OPC_LSB] == op);
  endfunction

  function automatic logic in_exec(input pmta_pkg::pmta_state_t s);
    in_exec = (s != pmta_pkg::pmta_idle);
  endfunction

  // decoder on q4 of first cycle; second cycle does the transfer
  always_comb begin
    take_read  = 1'b0;
    take_write = 1'b0;
    if (!in_exec(state) && instr_valid && q_phase == `PMTA_Q_LAST) begin
      take_read  = is_op(instr_low, `PMTA_OPC_READ);
      take_write = is_op(instr_low, `PMTA_OPC_WRITE);
    end
  end

  // unknown opcodes leave the mode untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= pmta_pkg::pmta_mode_none;
    end else if (take_read || take_write) begin
      mode <= pmta_pkg::pmta_mode_t'(instr_low[`PMTA_MODE_MSB:0]);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= pmta_pkg::pmta_idle;
    end else begin
      case (state)
        pmta_pkg::pmta_idle: begin
          if (take_read) begin
            state <= pmta_pkg::pmta_read_exec;
          end else if (take_write) begin
            state <= pmta_pkg::pmta_write_exec;
          end
        end
        pmta_pkg::pmta_read_exec,
        pmta_pkg::pmta_write_exec: begin
          if (q_phase == `PMTA_Q_LAST) begin
            state <= pmta_pkg::pmta_idle;
          end
        end
        default: state <= pmta_pkg::pmta_idle;
      endcase
    end
  end

  // pointer: pre-inc at q1 of second cycle, post modes at its q4
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      table_pointer <= `PMTA_PTR_RST;
    end else if (in_exec(state)) begin
      if (q_phase == `PMTA_Q_FIRST &&
          mode == pmta_pkg::pmta_mode_pre_inc) begin
        table_pointer <= step(table_pointer, 1'b0);
      end else if (q_phase == `PMTA_Q_LAST) begin
        case (mode)
          pmta_pkg::pmta_mode_post_inc:
            table_pointer <= step(table_pointer, 1'b0);
          pmta_pkg::pmta_mode_post_dec:
            table_pointer <= step(table_pointer, 1'b1);
          default: table_pointer <= table_pointer;
        endcase
      end
    end else if (ptr_load) begin
      table_pointer <= ptr_load_value;
    end
  end

  // memory request from pointer only, late phases of second cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd <= 1'b0;
    end else begin
      mem_rd <= state == pmta_pkg::pmta_read_exec &&
                q_phase != `PMTA_Q_FIRST;
    end
  end

  // address trails the pointer by one clock, so pre-inc is seen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= `PMTA_PTR_RST;
    end else begin
      mem_addr <= table_pointer;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byte_high <= 1'b0;
    end else begin
      byte_high <= table_pointer[0];
    end
  end

  // latch update in q4 of the read's second cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      table_latch <= `PMTA_LATCH_RST;
    end else if (state == pmta_pkg::pmta_read_exec &&
                 q_phase == `PMTA_Q_LAST) begin
      table_latch <= mem_rdata;
    end else if (latch_load && state == pmta_pkg::pmta_idle) begin
      table_latch <= latch_load_value;
    end
  end

  // write samples latch in q2, holding load in q4
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_byte <= `PMTA_LATCH_RST;
    end else if (state == pmta_pkg::pmta_write_exec &&
                 q_phase == `PMTA_Q_READ_LATCH) begin
      wr_byte <= table_latch;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= in_exec(state);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= in_exec(state) && q_phase == `PMTA_Q_LAST;
    end
  end

  // flag strobe kept as a flop so the core sees a clean zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_we <= 1'b0;
    end else begin
      status_we <= 1'b0;
    end
  end

  assign hold_load = state == pmta_pkg::pmta_write_exec &&
                     q_phase == `PMTA_Q_LAST;
  assign hold_data_sel = table_pointer;
  assign hold_sel = hold_data_sel[SEL_W-1:0];

  // holding outputs are flops inside the sub-module
  pmta_holding #(
    .DATA_W (DATA_W),
    .HOLD_N (HOLD_N),
    .SEL_W  (SEL_W)
  ) u_hold (
    .clock     (clock),
    .rst_n     (rst_n),
    .load      (hold_load),
    .sel       (hold_sel),
    .data_in   (wr_byte),
    .hold_flat (hold_data)
  );
endmodule
`default_nettype wire

// file: core/pmta_defs.svh
// constants for the program memory table access block
`ifndef PMTA_DEFS_SVH
`define PMTA_DEFS_SVH
`define PMTA_PTR_W        21
`define PMTA_DATA_W       8
`define PMTA_HOLD_N       8
`define PMTA_HOLD_SEL_W   3
`define PMTA_PTR_RST      21'h000000
`define PMTA_LATCH_RST    8'h00
`define PMTA_HOLD_RST     8'hff
`define PMTA_OPC_READ     6'h02
`define PMTA_OPC_WRITE    6'h03
`define PMTA_OPC_MSB      5
`define PMTA_OPC_LSB      2
`define PMTA_MODE_MSB     1
`define PMTA_Q_FIRST      2'h0
`define PMTA_Q_LAST       2'h3
`define PMTA_Q_READ_LATCH 2'h1
`endif

// file: core/pmta_pkg.sv
// types for the program memory table access block
`default_nettype none
package pmta_pkg;
  typedef enum logic [1:0] {
    pmta_mode_none,
    pmta_mode_post_inc,
    pmta_mode_post_dec,
    pmta_mode_pre_inc
  } pmta_mode_t;
  typedef enum logic [1:0] {
    pmta_idle,
    pmta_read_exec,
    pmta_write_exec
  } pmta_state_t;
endpackage
`default_nettype wire

// file: core/pmta_holding.sv
// holding registers loaded by table writes
`timescale 1ns/1ps
`default_nettype none
`include "pmta_defs.svh"
module pmta_holding #(
  parameter int DATA_W = `PMTA_DATA_W,
  parameter int HOLD_N = `PMTA_HOLD_N,
  parameter int SEL_W  = `PMTA_HOLD_SEL_W
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       load,
  input  wire logic [SEL_W-1:0]           sel,
  input  wire logic [DATA_W-1:0]          data_in,
  output var  logic [HOLD_N*DATA_W-1:0]   hold_flat
);
  genvar i;
  generate
    for (i = 0; i < HOLD_N; i++) begin : g_hold
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          hold_flat[i*DATA_W +: DATA_W] <= `PMTA_HOLD_RST;
        end else if (load && sel == SEL_W'(i)) begin
          hold_flat[i*DATA_W +: DATA_W] <= data_in;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: sim/pmta_mem_model.sv
// program memory model answering table reads
`timescale 1ns/1ps
`default_nettype none
module pmta_mem_model (
  input  wire logic        clock,
  input  wire logic        mem_rd,
  input  wire logic [20:0] mem_addr,
  output var  logic [7:0]  mem_rdata
);
  logic [7:0] last = 8'h00;
  logic       rd_q = 1'b0;
  always @(posedge clock) rd_q <= mem_rd;
  always @(posedge clock) if (mem_rd) last <= mem_rdata;
  // one byte per address, odd and even differ
  // stale bus shows inverse so old data never passes as valid
  always_comb
    mem_rdata = (mem_rd || rd_q) ? mem_addr[7:0] ^ {3'h0, mem_addr[20:16]}
                                 : ~last;
endmodule
`default_nettype wire

// file: sim/pmta_core_assertions.sv
// assertions on the table access execution ports
`timescale 1ns/1ps
`default_nettype none
`include "pmta_defs.svh"
module pmta_checker (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic [1:0]  q_phase,
  input wire logic        instr_valid,
  input wire logic [7:0]  instr_low,
  input wire logic [7:0]  mem_rdata,
  input wire logic [20:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        byte_high,
  input wire logic [20:0] table_pointer,
  input wire logic [7:0]  table_latch,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        status_we,
  input wire logic [63:0] hold_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic       go;
  logic [1:0] md;
  assign go = q_phase == 2'h3 && instr_valid && !busy &&
              instr_low[7:3] == 5'h01;
  assign md = instr_low[1:0];
  property p_flags; status_we == 1'b0; endproperty
  a_flags: assert property (p_flags) else $error("flag write");
  property p_addr; mem_addr == $past(table_pointer); endproperty
  a_addr: assert property (p_addr) else $error("bad addr");
  property p_byte; byte_high == $past(table_pointer[0]); endproperty
  a_byte: assert property (p_byte) else $error("bad byte");
  property p_done; go |-> ##1 !done [*4] ##1 done; endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_rd;
    go && !instr_low[2] |-> ##2 !mem_rd ##1 mem_rd [*3] ##1 !mem_rd;
  endproperty
  a_rd: assert property (p_rd) else $error("bad read strobe");
  property p_wr_quiet;
    go && instr_low[2] |-> ##1 !mem_rd [*6];
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write read");
  property p_latch;
    go && !instr_low[2] |-> ##5 table_latch == $past(mem_rdata);
  endproperty
  a_latch: assert property (p_latch) else $error("bad latch");
  property p_pre;
    go && md == 2'h3 |-> ##2 table_pointer == $past(table_pointer, 2) + 21'h1;
  endproperty
  a_pre: assert property (p_pre) else $error("bad pre");
  property p_inc;
    go && md == 2'h1 |-> ##5 table_pointer == $past(table_pointer, 5) + 21'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("bad inc");
  property p_dec;
    go && md == 2'h2 |-> ##5 table_pointer == $past(table_pointer, 5) - 21'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("bad dec");
  property p_keep;
    go && md == 2'h0 |-> ##5 table_pointer == $past(table_pointer, 5);
  endproperty
  a_keep: assert property (p_keep) else $error("bad keep");
  property p_hold;
    go && instr_low[2] && md != 2'h3 |-> ##5 $past(table_latch, 5) ==
      8'(hold_data >> {$past(table_pointer[2:0], 5), 3'h0});
  endproperty
  a_hold: assert property (p_hold) else $error("bad hold");
endmodule
bind pmta_core pmta_checker pmta_checker_inst (.clock, .arst_n, .q_phase,
  .instr_valid, .instr_low, .mem_rdata, .mem_addr, .mem_rd, .byte_high,
  .table_pointer, .table_latch, .busy, .done, .status_we, .hold_data);
`default_nettype wire

// file: sim/test_program_memory_table_access.sv
// self-checking bench for table read and write execution
`timescale 1ns/1ps
`default_nettype none
module test_program_memory_table_access;
  logic        clock = 1'b0, arst_n = 1'b0, instr_valid = 1'b0;
  logic        ptr_load = 1'b0, latch_load = 1'b0;
  logic [1:0]  q_phase = 2'h0;
  logic [7:0]  instr_low = 8'h00, latch_load_value = 8'h00, op, lat;
  logic [20:0] ptr_load_value = 21'h0, p, mem_addr, table_pointer;
  logic [7:0]  mem_rdata, table_latch;
  logic        mem_rd, byte_high, busy, done, status_we;
  logic [63:0] hold_data, hold;
  logic [92:0] notes[$], want;
  logic [31:0] k;
  int          miscompares = 0, check_count = 0, cycles = 0, i;
  integer      seed = 32'ha64b0485;
  pmta_core pmta_core_inst (.clock, .arst_n, .q_phase, .instr_valid,
    .instr_low, .ptr_load, .ptr_load_value, .latch_load, .latch_load_value,
    .mem_rdata, .mem_addr, .mem_rd, .byte_high, .table_pointer, .table_latch,
    .busy, .done, .status_we, .hold_data);
  pmta_mem_model pmta_mem_model_inst (.clock, .mem_rd, .mem_addr, .mem_rdata);
  always #20 clock = ~clock;
  always @(negedge clock) q_phase <= q_phase + 2'h1;
  task final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cmp(input logic [92:0] got, input logic [92:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task to_phase(input logic [1:0] ph);
    do @(posedge clock); while (q_phase !== ph - 2'h1);
    @(negedge clock);
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  // results read mid-cycle, after the done edge has settled
  always @(negedge clock) begin
    if (done === 1'b1) begin
      want = notes.size() ? notes.pop_front() : 93'h0;
      cmp({table_pointer, table_latch, hold_data}, want);
    end
  end
  initial begin
    p = 21'h0;
    lat = 8'h00;
    hold = {8{8'hff}};
    repeat (3) @(posedge clock);
    @(negedge clock) arst_n <= 1'b1;
    repeat (4) @(negedge clock);
    cmp({table_pointer, table_latch, hold_data}, {p, lat, hold});
    for (i = 0; i < 48; i++) begin
      k = $random(seed);
      op = k[7:5] != 3'h0 ? {5'h01, k[2:0]} : {1'b1, k[6:0]};
      to_phase(2);
      if (k[8] || i % 8 < 2) begin
        // wrap corners: top with pre-inc read, zero with post-dec write
        p = i % 8 == 0 ? 21'h1fffff : i % 8 == 1 ? 21'h0 : 21'(k[31:11]);
        op = i % 8 == 0 ? 8'h0b : i % 8 == 1 ? 8'h0e : op;
        lat = k[19:12];
        ptr_load <= 1'b1;
        ptr_load_value <= p;
        latch_load <= 1'b1;
        latch_load_value <= lat;
      end
      to_phase(3);
      ptr_load <= 1'b0;
      latch_load <= 1'b0;
      instr_valid <= 1'b1;
      instr_low <= op;
      to_phase(0);
      instr_valid <= 1'b0;
      if (op[7:3] == 5'h01) begin
        if (op[1:0] == 2'h3) p = p + 21'h1;
        if (!op[2]) lat = p[7:0] ^ {3'h0, p[20:16]};
        else hold[{p[2:0], 3'h0} +: 8] = lat;
        if (op[1:0] == 2'h1) p = p + 21'h1;
        if (op[1:0] == 2'h2) p = p - 21'h1;
        notes.push_back({p, lat, hold});
        // software loads mid-instruction must be refused
        to_phase(2);
        ptr_load <= 1'b1;
        ptr_load_value <= ~p;
        latch_load <= 1'b1;
        latch_load_value <= ~lat;
        to_phase(3);
        ptr_load <= 1'b0;
        latch_load <= 1'b0;
      end
    end
    repeat (12) @(posedge clock);
    cmp(93'(notes.size()), 93'h0);
    final_report;
  end
endmodule
`default_nettype wire
